/* File: hdl/dds_regs.vh */
// Constants for the dual converter serial control block.
`ifndef DDS_REGS_VH
`define DDS_REGS_VH
`define DDS_WORD_BITS      5'h10
`define DDS_CODE_ZERO      12'h000
`define DDS_CODE_MID       12'h800
`define DDS_CMD_EXT        3'h0
`define DDS_CMD_LD_A       3'h1
`define DDS_CMD_LD_A_UPD   3'h2
`define DDS_CMD_LD_ALL     3'h3
`define DDS_CMD_UPD_ALL    3'h4
`define DDS_CMD_LD_B       3'h5
`define DDS_CMD_LD_B_UPD   3'h6
`define DDS_CMD_SHUT_BOTH  3'h7
`define DDS_EXT_UPD_A      3'h1
`define DDS_EXT_FULL_PD    3'h3
`define DDS_EXT_UPD_B      3'h5
`define DDS_EXT_SHUT_A     3'h6
`define DDS_EXT_SHUT_B     3'h7
`define DDS_CMD_MSB        15
`define DDS_CMD_LSB        13
`define DDS_DATA_MSB       12
`define DDS_DATA_LSB       1
`define DDS_EXT_MSB        12
`define DDS_EXT_LSB        10
`define DDS_P1_HI          9
`define DDS_P1_LO          8
`endif

/* File: hdl/dds_serial_ctrl.v */
// Serial control logic for a dual 12-bit converter.
`include "dds_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Shift input bit on serial clock rise.
// - One 16-bit shift register, also drives output.
// - Each channel: input register then converter register.
// - Reset level select: high midscale, low zero.
// - Clear forces all four registers to level.
// - Lockout low ignores every shutdown command.
// - Per channel termination selection held.
// - Word: three command, twelve data, pad.
// - Select rise executes the received word only after exactly 16 clock rises.
// - Decode loads, updates, shutdowns, power-down.
// - Transfer strobe copies input to converter.
module dds_serial_ctrl #(
  parameter W = 12
) (
  // Clock, enable and reset.
  input  wire         CLK_I,
  input  wire         CE_I,
  input  wire         RST_N_I,
  // Serial link pins.
  input  wire         SCLK_I,
  input  wire         CS_N_I,
  input  wire         DIN_I,
  output reg          DOUT_O,
  // Control pins.
  input  wire         RESET_LEVEL_SELECT_I,
  input  wire         REGISTER_WIPE_N_I,
  input  wire         SHUTDOWN_LOCKOUT_N_I,
  input  wire         TRANSFER_STROBE_N_I,
  // Channel state.
  output reg  [W-1:0] CODE_A_O,
  output reg  [W-1:0] CODE_B_O,
  output reg          SHUT_A_O,
  output reg          SHUT_B_O,
  output reg          CHAN_A_TERMINATION_SEL_O,
  output reg          CHAN_B_TERMINATION_SEL_O,
  output reg          FULL_PD_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for every pin input.
  reg [6:0] s1;
  reg [6:0] s2;
  reg       sclk_d;
  reg       cs_d;
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s1     <= 7'h7A;
      s2     <= 7'h7A;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else if (CE_I) begin
      s1     <= {TRANSFER_STROBE_N_I, SHUTDOWN_LOCKOUT_N_I, REGISTER_WIPE_N_I,
                 CS_N_I, SCLK_I, RESET_LEVEL_SELECT_I, DIN_I};
      s2     <= s1;
      sclk_d <= s2[2];
      cs_d   <= s2[3];
    end
  end
  wire din     = s2[0];
  wire lvl     = s2[1];
  wire sclk    = s2[2];
  wire cs_n    = s2[3];
  wire wipe_n  = s2[4];
  wire lock_n  = s2[5];
  wire xfer_n  = s2[6];
  wire sclk_up = sclk & ~sclk_d & ~cs_n;
  wire sclk_dn = ~sclk & sclk_d & ~cs_n;
  wire cs_up   = cs_n & ~cs_d;
  wire [W-1:0] rst_code = lvl ? `DDS_CODE_MID : `DDS_CODE_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and edge counter.
  reg [15:0] shreg;
  reg [4:0]  cnt;
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      shreg  <= 16'h0000;
      cnt    <= 5'h00;
      DOUT_O <= 1'b0;
    end else if (CE_I) begin
      if (sclk_up) begin
        shreg <= {shreg[14:0], din};
        if (cnt != 5'h1F)
          cnt <= cnt + 5'h01;
      end
      if (sclk_dn)
        DOUT_O <= shreg[15];
      if (cs_up)
        cnt <= 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word decode and channel storage.
  wire [2:0]   cmd  = shreg[`DDS_CMD_MSB:`DDS_CMD_LSB];
  wire [W-1:0] data = shreg[`DDS_DATA_MSB:`DDS_DATA_LSB];
  wire [2:0]   ext  = shreg[`DDS_EXT_MSB:`DDS_EXT_LSB];
  wire         p1a  = shreg[`DDS_P1_HI];
  wire         p1b  = shreg[`DDS_P1_LO];
  wire         go   = cs_up & (cnt == `DDS_WORD_BITS);
  reg [W-1:0] in_a;
  reg [W-1:0] in_b;
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      in_a      <= `DDS_CODE_ZERO;
      in_b      <= `DDS_CODE_ZERO;
      CODE_A_O  <= `DDS_CODE_ZERO;
      CODE_B_O  <= `DDS_CODE_ZERO;
      SHUT_A_O  <= 1'b0;
      SHUT_B_O  <= 1'b0;
      CHAN_A_TERMINATION_SEL_O <= 1'b0;
      CHAN_B_TERMINATION_SEL_O <= 1'b0;
      FULL_PD_O <= 1'b0;
    end else if (CE_I) begin
      if (!wipe_n) begin
        in_a     <= rst_code;
        in_b     <= rst_code;
        CODE_A_O <= rst_code;
        CODE_B_O <= rst_code;
      end else begin
        if (go) begin
          case (cmd)
            `DDS_CMD_LD_A: in_a <= data;
            `DDS_CMD_LD_B: in_b <= data;
            `DDS_CMD_LD_A_UPD: begin
              in_a     <= data;
              CODE_A_O <= data;
              CODE_B_O <= in_b;
              SHUT_A_O <= 1'b0;
              SHUT_B_O <= 1'b0;
              FULL_PD_O <= 1'b0;
            end
            `DDS_CMD_LD_B_UPD: begin
              in_b     <= data;
              CODE_B_O <= data;
              CODE_A_O <= in_a;
              SHUT_A_O <= 1'b0;
              SHUT_B_O <= 1'b0;
              FULL_PD_O <= 1'b0;
            end
            `DDS_CMD_LD_ALL: begin
              in_a     <= data;
              in_b     <= data;
              CODE_A_O <= data;
              CODE_B_O <= data;
              SHUT_A_O <= 1'b0;
              SHUT_B_O <= 1'b0;
              FULL_PD_O <= 1'b0;
            end
            `DDS_CMD_UPD_ALL: begin
              CODE_A_O <= in_a;
              CODE_B_O <= in_b;
              SHUT_A_O <= 1'b0;
              SHUT_B_O <= 1'b0;
              FULL_PD_O <= 1'b0;
            end
            `DDS_CMD_SHUT_BOTH: begin
              if (lock_n) begin
                SHUT_A_O <= 1'b1;
                SHUT_B_O <= 1'b1;
                CHAN_A_TERMINATION_SEL_O <= shreg[`DDS_DATA_MSB];
                CHAN_B_TERMINATION_SEL_O <= shreg[`DDS_DATA_MSB - 1];
              end
            end
            `DDS_CMD_EXT: begin
              case (ext)
                `DDS_EXT_UPD_A: begin
                  CODE_A_O  <= in_a;
                  SHUT_A_O  <= 1'b0;
                  FULL_PD_O <= 1'b0;
                end
                `DDS_EXT_UPD_B: begin
                  CODE_B_O  <= in_b;
                  SHUT_B_O  <= 1'b0;
                  FULL_PD_O <= 1'b0;
                end
                `DDS_EXT_FULL_PD: begin
                  if (lock_n) begin
                    SHUT_A_O  <= 1'b1;
                    SHUT_B_O  <= 1'b1;
                    FULL_PD_O <= 1'b1;
                    CHAN_A_TERMINATION_SEL_O <= p1a;
                    CHAN_B_TERMINATION_SEL_O <= p1b;
                  end
                end
                `DDS_EXT_SHUT_A: begin
                  if (lock_n) begin
                    SHUT_A_O <= 1'b1;
                    CHAN_A_TERMINATION_SEL_O <= p1a;
                  end
                end
                `DDS_EXT_SHUT_B: begin
                  if (lock_n) begin
                    SHUT_B_O <= 1'b1;
                    CHAN_B_TERMINATION_SEL_O <= p1a;
                  end
                end
                default: ;
              endcase
            end
            default: ;
          endcase
        end else if (!xfer_n) begin
          CODE_A_O <= in_a;
          CODE_B_O <= in_b;
        end
      end
      if (!lock_n) begin
        SHUT_A_O  <= 1'b0;
        SHUT_B_O  <= 1'b0;
        FULL_PD_O <= 1'b0;
      end
    end
  end

endmodule // dds_serial_ctrl

/* File: dv/dds_host_model.sv */
// Serial host model that shifts words into the block.
module dds_host_model (
  // Clock.
  input  wire logic clk_i,
  // Serial lines.
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end
  // Sends the first n bits of w, most significant first; clock idles low.
  task automatic send(input logic [15:0] w, input int n);
    @(posedge clk_i) cs_n_o <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      din_o <= w[i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    din_o  <= ~din_o;
    repeat (12) @(posedge clk_i);
  endtask
endmodule // dds_host_model

/* File: dv/dds_serial_ctrl_sva.sv */
// Checker for the dual converter serial control block.
`include "dds_regs.vh"
module dds_serial_ctrl_sva #(
  parameter W = 12
) (
  // Clock and controls.
  input wire logic         CLK_I,
  input wire logic         CE_I,
  input wire logic         RST_N_I,
  input wire logic         SCLK_I,
  input wire logic         CS_N_I,
  input wire logic         DIN_I,
  input wire logic         RESET_LEVEL_SELECT_I,
  input wire logic         REGISTER_WIPE_N_I,
  input wire logic         SHUTDOWN_LOCKOUT_N_I,
  input wire logic         TRANSFER_STROBE_N_I,
  // Outputs.
  input wire logic         DOUT_O,
  input wire logic [W-1:0] CODE_A_O,
  input wire logic [W-1:0] CODE_B_O,
  input wire logic         SHUT_A_O,
  input wire logic         SHUT_B_O,
  input wire logic         CHAN_A_TERMINATION_SEL_O,
  input wire logic         CHAN_B_TERMINATION_SEL_O,
  input wire logic         FULL_PD_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_wipe_mid;
    (!REGISTER_WIPE_N_I && RESET_LEVEL_SELECT_I)[*4] |->
      CODE_A_O == `DDS_CODE_MID && CODE_B_O == `DDS_CODE_MID;
  endproperty
  a_wipe_mid: assert property (p_wipe_mid) else $error("wipe mid");
  property p_wipe_zero;
    (!REGISTER_WIPE_N_I && !RESET_LEVEL_SELECT_I)[*4] |->
      CODE_A_O == `DDS_CODE_ZERO && CODE_B_O == `DDS_CODE_ZERO;
  endproperty
  a_wipe_zero: assert property (p_wipe_zero) else $error("wipe zero");
  property p_lock;
    (!SHUTDOWN_LOCKOUT_N_I)[*4] |-> !SHUT_A_O && !SHUT_B_O && !FULL_PD_O;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout");
  property p_quiet;
    (CS_N_I && REGISTER_WIPE_N_I && TRANSFER_STROBE_N_I)[*6] |=>
      $stable(CODE_A_O) && $stable(CODE_B_O);
  endproperty
  a_quiet: assert property (p_quiet) else $error("code moved");
  property p_dout;
    CS_N_I[*6] |=> $stable(DOUT_O);
  endproperty
  a_dout: assert property (p_dout) else $error("dout moved");
  property p_term;
    (CS_N_I && REGISTER_WIPE_N_I)[*6] |=>
      $stable(CHAN_A_TERMINATION_SEL_O) && $stable(CHAN_B_TERMINATION_SEL_O);
  endproperty
  a_term: assert property (p_term) else $error("term moved");
  property p_strobe;
    (CS_N_I && SHUTDOWN_LOCKOUT_N_I)[*6] ##0
      (!TRANSFER_STROBE_N_I && SHUT_A_O) |=> SHUT_A_O;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe woke");
  property p_rise;
    $rose(SHUT_A_O) || $rose(SHUT_B_O) || $rose(FULL_PD_O) |->
      CS_N_I && $past(CS_N_I, 3);
  endproperty
  a_rise: assert property (p_rise) else $error("early shut");
endmodule // dds_serial_ctrl_sva
bind dds_serial_ctrl dds_serial_ctrl_sva #(.W(W)) u_dds_serial_ctrl_sva (.*);

/* File: dv/tb_top.sv */
// Top bench for the dual converter serial control block.
`include "dds_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, lvl = 1'b0;
  logic        wipe_n = 1'b1, lock_n = 1'b1, strb_n = 1'b1;
  logic        ce = 1'b1;
  wire  logic  sclk, cs_n, din, dout, sh_a, sh_b, tm_a, tm_b, pd;
  wire  logic [11:0] ca, cb;
  wire  logic [11:0] st = {7'h00, pd, sh_a, sh_b, tm_a, tm_b};
  int          mismatches = 0, n_tests = 0, cycles = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  dds_host_model u_dds_host_model (.clk_i(clk), .sclk_o(sclk),
    .cs_n_o(cs_n), .din_o(din));
  dds_serial_ctrl u_dds_serial_ctrl (.CLK_I(clk), .CE_I(ce),
    .RST_N_I(rst_n), .SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din),
    .DOUT_O(dout), .RESET_LEVEL_SELECT_I(lvl), .REGISTER_WIPE_N_I(wipe_n),
    .SHUTDOWN_LOCKOUT_N_I(lock_n), .TRANSFER_STROBE_N_I(strb_n),
    .CODE_A_O(ca), .CODE_B_O(cb), .SHUT_A_O(sh_a), .SHUT_B_O(sh_b),
    .CHAN_A_TERMINATION_SEL_O(tm_a), .CHAN_B_TERMINATION_SEL_O(tm_b),
    .FULL_PD_O(pd));
  task chk(input string nm, input logic [11:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task go(input logic [15:0] w, input int n, input logic [11:0] ea, eb);
    u_dds_host_model.send(w, n);
    chk("code_a", ca, ea);
    chk("code_b", cb, eb);
  endtask
  task pins(input logic l, wn, kn, sn);
    @(posedge clk) {lvl, wipe_n, lock_n, strb_n} <= {l, wn, kn, sn};
    repeat (8) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    go({`DDS_CMD_LD_A, 12'hABC, 1'b0}, 16, 12'h000, 12'h000);
    go({`DDS_CMD_UPD_ALL, 12'h000, 1'b0}, 16, 12'hABC, 12'h000);
    go({`DDS_CMD_LD_B_UPD, 12'h123, 1'b0}, 16, 12'hABC, 12'h123);
    chk("dout", {11'h000, dout}, 12'h001);
    go({`DDS_CMD_LD_ALL, 12'h555, 1'b0}, 15, 12'hABC, 12'h123);
    go({`DDS_CMD_LD_ALL, 12'h555, 1'b0}, 16, 12'h555, 12'h555);
    go({`DDS_CMD_LD_B, 12'h0F0, 1'b0}, 16, 12'h555, 12'h555);
    go({3'h0, `DDS_EXT_UPD_B, 10'h000}, 16, 12'h555, 12'h0F0);
    go({`DDS_CMD_LD_A_UPD, 12'h777, 1'b0}, 16, 12'h777, 12'h0F0);
    go({`DDS_CMD_LD_B, 12'h321, 1'b0}, 16, 12'h777, 12'h0F0);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    chk("strobe", cb, 12'h321);
    pins(1'b0, 1'b1, 1'b0, 1'b1);
    go({`DDS_CMD_SHUT_BOTH, 2'b10, 11'h000}, 16, 12'h777, 12'h321);
    chk("locked", {10'h000, sh_a, sh_b}, 12'h000);
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    go({`DDS_CMD_SHUT_BOTH, 2'b10, 11'h000}, 16, 12'h777, 12'h321);
    chk("shut", st, 12'h00E);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    chk("shut_strobe", st, 12'h00E);
    go({3'h0, `DDS_EXT_UPD_A, 10'h000}, 16, 12'h777, 12'h321);
    chk("wake_a", st, 12'h006);
    go({3'h0, `DDS_EXT_FULL_PD, 2'b01, 8'h00}, 16, 12'h777, 12'h321);
    chk("full_pd", {9'h000, pd, tm_a, tm_b}, 12'h005);
    pins(1'b0, 1'b1, 1'b0, 1'b1);
    chk("wake", {9'h000, pd, sh_a, sh_b}, 12'h000);
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    go({3'h0, `DDS_EXT_SHUT_B, 1'b0, 9'h000}, 16, 12'h777, 12'h321);
    chk("shut_b", st, 12'h004);
    go({3'h0, `DDS_EXT_SHUT_A, 1'b1, 9'h000}, 16, 12'h777, 12'h321);
    chk("shut_a", st, 12'h00E);
    ce <= 1'b0;
    go({`DDS_CMD_LD_ALL, 12'hFFF, 1'b0}, 16, 12'h777, 12'h321);
    ce <= 1'b1;
    pins(1'b1, 1'b0, 1'b1, 1'b1);
    chk("wipe_mid", ca & cb, `DDS_CODE_MID);
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    chk("wipe_zero", ca | cb, `DDS_CODE_ZERO);
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    summarize();
  end
endmodule // tb_top
